//--- hw/etc_top.sv
// top of the encoder tick counter: apb slave, counter, status and interrupt
// assumes apb master on CLK, encoder pins sampled on CLK
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module etc_top (
  input  wire logic        CLK,      // 25 MHz system clock
  input  wire logic        RST_N,    // synchronous active-low reset
  input  wire logic        PSEL,     // apb select
  input  wire logic        PENABLE,  // apb access phase
  input  wire logic        PWRITE,   // apb direction
  input  wire logic [7:0]  PADDR,    // apb byte address
  input  wire logic [31:0] PWDATA,   // apb write data
  output logic      [31:0] PRDATA,   // apb read data
  output logic             PREADY,   // apb ready
  output logic             PSLVERR,  // apb error
  input  wire logic        ENC_A,    // phase a or step
  input  wire logic        ENC_B,    // phase b or direction
  output logic             IRQ       // level interrupt
);
  // ****************************************************************
  // state
  // ****************************************************************
  logic        mode_r;     // signal mode
  logic        run_r;      // counting enabled
  logic [31:0] count_r;    // tick count
  logic        dir_r;      // last direction
  logic        wrap_r;     // wrap flag
  logic [etc_pkg::EVT_N-1:0] ist_r; // sticky events
  logic [etc_pkg::EVT_N-1:0] imk_r; // mask
  logic        tick;       // decoded tick
  logic        down;       // decoded direction
  logic        wr_acc;     // write access edge
  logic        rd_acc;     // read access edge
  logic        hit;        // mapped address
  logic        cmd_open, cmd_start, cmd_stop, cmd_clr;
  logic        cnt_en;     // counting this cycle
  logic        wrap_ev;    // this tick wraps
  logic [etc_pkg::EVT_N-1:0] ev; // event vector
  logic [31:0] rd_nxt;     // read mux

  etc_decoder u_dec (
    .clk   (CLK),
    .rst_n (RST_N),
    .mode  (mode_r),
    .in_a  (ENC_A),
    .in_b  (ENC_B),
    .tick  (tick),
    .down  (down)
  );

  // ****************************************************************
  // apb decode: ready is registered, so access takes two cycles
  // ****************************************************************
  assign hit = PADDR == etc_pkg::ADDR_CTRL || PADDR == etc_pkg::ADDR_COUNT ||
               PADDR == etc_pkg::ADDR_STATUS || PADDR == etc_pkg::ADDR_IRQ_ST ||
               PADDR == etc_pkg::ADDR_IRQ_MK;
  assign wr_acc = PSEL & PENABLE & PREADY & PWRITE;
  assign rd_acc = PSEL & PENABLE & ~PREADY & ~PWRITE;
  assign cmd_open  = wr_acc && PADDR == etc_pkg::ADDR_CTRL && PWDATA[etc_pkg::CTRL_OPEN];
  assign cmd_start = wr_acc && PADDR == etc_pkg::ADDR_CTRL && PWDATA[etc_pkg::CTRL_START];
  assign cmd_stop  = wr_acc && PADDR == etc_pkg::ADDR_CTRL && PWDATA[etc_pkg::CTRL_STOP];
  assign cmd_clr   = wr_acc && PADDR == etc_pkg::ADDR_CTRL && PWDATA[etc_pkg::CTRL_CLEAR];

  // pready pulses one cycle in access phase
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~hit; // unmapped address
    end
  end

  // read mux
  always_comb begin
    rd_nxt = etc_pkg::RD_ZERO;
    unique case (PADDR)
      etc_pkg::ADDR_CTRL:   rd_nxt[etc_pkg::CTRL_MODE] = mode_r;
      etc_pkg::ADDR_COUNT:  rd_nxt = count_r;
      etc_pkg::ADDR_STATUS: begin
        rd_nxt[etc_pkg::STAT_RUN]  = run_r;
        rd_nxt[etc_pkg::STAT_DIR]  = dir_r;
        rd_nxt[etc_pkg::STAT_WRAP] = wrap_r;
      end
      etc_pkg::ADDR_IRQ_ST: rd_nxt[etc_pkg::EVT_N-1:0] = ist_r;
      etc_pkg::ADDR_IRQ_MK: rd_nxt[etc_pkg::EVT_N-1:0] = imk_r;
      default:              rd_nxt = etc_pkg::RD_ZERO;
    endcase
  end

  // read data registered with pready
  always_ff @(posedge CLK) begin
    if (!RST_N)
      PRDATA <= etc_pkg::RD_ZERO;
    else if (rd_acc)
      PRDATA <= rd_nxt;
  end

  // ****************************************************************
  // mode and run control
  // ****************************************************************
  // mode taken on open; quadrature after reset
  always_ff @(posedge CLK) begin
    if (!RST_N)
      mode_r <= etc_pkg::MODE_QUAD;
    else if (cmd_open)
      mode_r <= PWDATA[etc_pkg::CTRL_MODE];
  end

  // run flag: open starts unless told not to, stop wins over start
  always_ff @(posedge CLK) begin
    if (!RST_N)
      run_r <= 1'b0;
    else if (cmd_stop)
      run_r <= 1'b0;
    else if (cmd_open)
      run_r <= ~PWDATA[etc_pkg::CTRL_NOSTRT];
    else if (cmd_start)
      run_r <= 1'b1;
  end

  // ****************************************************************
  // counter, direction and wrap
  // ****************************************************************
  assign cnt_en  = run_r & tick;
  assign wrap_ev = cnt_en & (down ? count_r == 32'h0000_0000 : count_r == 32'hffff_ffff);

  // clear beats a same-cycle tick; modulo wrap
  always_ff @(posedge CLK) begin
    if (!RST_N)
      count_r <= 32'h0000_0000;
    else if (cmd_clr || cmd_open)
      count_r <= 32'h0000_0000;
    else if (cnt_en)
      count_r <= down ? count_r - 32'h0000_0001 : count_r + 32'h0000_0001;
  end

  // direction of latest counted tick
  always_ff @(posedge CLK) begin
    if (!RST_N)
      dir_r <= 1'b0;
    else if (cnt_en)
      dir_r <= down;
  end

  // wrap flag sticks until clear or open; a wrap in the same cycle wins
  always_ff @(posedge CLK) begin
    if (!RST_N)
      wrap_r <= 1'b0;
    else if (wrap_ev)
      wrap_r <= 1'b1;
    else if (cmd_clr || cmd_open)
      wrap_r <= 1'b0;
  end

  // ****************************************************************
  // interrupts: sticky w1c status, mask, level output
  // ****************************************************************
  assign ev[etc_pkg::EVT_TICK] = cnt_en;
  assign ev[etc_pkg::EVT_WRAP] = wrap_ev;

  genvar gi;
  generate
    for (gi = 0; gi < etc_pkg::EVT_N; gi++) begin : g_evt
      // set beats write-one clear
      always_ff @(posedge CLK) begin
        if (!RST_N)
          ist_r[gi] <= 1'b0;
        else if (ev[gi])
          ist_r[gi] <= 1'b1;
        else if (wr_acc && PADDR == etc_pkg::ADDR_IRQ_ST && PWDATA[gi])
          ist_r[gi] <= 1'b0;
      end
    end
  endgenerate

  // mask register
  always_ff @(posedge CLK) begin
    if (!RST_N)
      imk_r <= '0;
    else if (wr_acc && PADDR == etc_pkg::ADDR_IRQ_MK)
      imk_r <= PWDATA[etc_pkg::EVT_N-1:0];
  end

  // registered interrupt level, one cycle behind status
  always_ff @(posedge CLK) begin
    if (!RST_N)
      IRQ <= 1'b0;
    else
      IRQ <= |(ist_r & imk_r);
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_stop_hold;
    @(posedge CLK) disable iff (!RST_N)
      (!run_r && !cmd_clr && !cmd_open) |=> count_r == $past(count_r);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("count moved while stopped");

  property p_clear;
    @(posedge CLK) disable iff (!RST_N) cmd_clr |=> count_r == 32'h0000_0000;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not zero count");

  property p_count;
    @(posedge CLK) disable iff (!RST_N)
      (cnt_en && !cmd_clr && !cmd_open) |=>
        count_r == ($past(down) ? $past(count_r) - 32'h0000_0001 : $past(count_r) + 32'h0000_0001);
  endproperty
  a_count: assert property (p_count) else $error("count step wrong");

  property p_open_run;
    @(posedge CLK) disable iff (!RST_N)
      (cmd_open && !cmd_stop && !PWDATA[etc_pkg::CTRL_NOSTRT]) |=> run_r;
  endproperty
  a_open_run: assert property (p_open_run) else $error("open did not start");

  property p_dir;
    @(posedge CLK) disable iff (!RST_N) cnt_en |=> dir_r == $past(down);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not updated");

  property p_wrap;
    @(posedge CLK) disable iff (!RST_N) wrap_ev |=> wrap_r ##1 1'b1;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag not set");

  property p_mode;
    @(posedge CLK) disable iff (!RST_N) !cmd_open |=> mode_r == $past(mode_r);
  endproperty
  a_mode: assert property (p_mode) else $error("mode changed without open");

  property p_step;
    @(posedge CLK) disable iff (!RST_N)
      (mode_r == etc_pkg::MODE_STEP && tick) |->
        $past(ENC_A, 2) && !$past(ENC_A, 3) && down == $past(ENC_B, 2);
  endproperty
  a_step: assert property (p_step) else $error("step direction wrong");

  property p_quad;
    @(posedge CLK) disable iff (!RST_N)
      (mode_r == etc_pkg::MODE_QUAD &&
       ($past(ENC_A, 2) != $past(ENC_A, 3) || $past(ENC_B, 2) != $past(ENC_B, 3))) |-> tick;
  endproperty
  a_quad: assert property (p_quad) else $error("quadrature edge missed");

  // phase a moving counts up when it now differs from the old phase b level
  property p_quad_dir;
    @(posedge CLK) disable iff (!RST_N)
      (mode_r == etc_pkg::MODE_QUAD && tick && $past(ENC_A, 2) != $past(ENC_A, 3)) |->
        down == ($past(ENC_A, 2) == $past(ENC_B, 3));
  endproperty
  a_quad_dir: assert property (p_quad_dir) else $error("quadrature direction wrong");

  // open also zeroes the count
  property p_open_clear;
    @(posedge CLK) disable iff (!RST_N) cmd_open |=> count_r == 32'h0000_0000;
  endproperty
  a_open_clear: assert property (p_open_clear) else $error("open did not zero count");

  // open with the stay-stopped bit leaves the counter stopped
  property p_open_nostart;
    @(posedge CLK) disable iff (!RST_N)
      (cmd_open && PWDATA[etc_pkg::CTRL_NOSTRT]) |=> !run_r;
  endproperty
  a_open_nostart: assert property (p_open_nostart) else $error("open started counter");

  // start alone sets the run flag
  property p_start;
    @(posedge CLK) disable iff (!RST_N) (cmd_start && !cmd_stop && !cmd_open) |=> run_r;
  endproperty
  a_start: assert property (p_start) else $error("start did not run");

  // stop always drops the run flag
  property p_stop;
    @(posedge CLK) disable iff (!RST_N) cmd_stop |=> !run_r;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not halt");

  // counting up from the top of the range comes back to zero
  property p_wrap_up;
    @(posedge CLK) disable iff (!RST_N)
      (cnt_en && !down && count_r == 32'hffff_ffff && !cmd_clr && !cmd_open) |=> count_r == 32'h0000_0000;
  endproperty
  a_wrap_up: assert property (p_wrap_up) else $error("upward wrap wrong");
endmodule : etc_top
`default_nettype wire

//--- hw/etc_pkg.sv
// constants, register map and enumerations for the encoder tick counter
// assumes one 25 MHz clock, synchronous active-low reset, apb register access
//
// Functional notes
// - mode 0 quadrature default, 1 step/direction
// - quadrature counts every edge of either phase
// - step mode counts step rising edge by direction
// - direction status 0 up, 1 down
// - reset command clears the count
// - start lets ticks change the count
// - stop freezes count until next start or an open without the stay-stopped bit; clear or open still zeroes it
// - open starts counting unless told otherwise
// - wrap flag readable alongside the count
package etc_pkg;
  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00; // mode, open, cmd bits
  localparam logic [7:0] ADDR_COUNT  = 8'h04; // tick count
  localparam logic [7:0] ADDR_STATUS = 8'h08; // run, dir, wrap
  localparam logic [7:0] ADDR_IRQ_ST = 8'h0c; // sticky events, w1c
  localparam logic [7:0] ADDR_IRQ_MK = 8'h10; // event mask

  // ****************************************************************
  // control register fields (command bits are write-only pulses)
  // ****************************************************************
  localparam int CTRL_MODE   = 0; // signal mode
  localparam int CTRL_OPEN   = 1; // open pulse
  localparam int CTRL_NOSTRT = 2; // with open: stay stopped
  localparam int CTRL_START  = 3; // start pulse
  localparam int CTRL_STOP   = 4; // stop pulse
  localparam int CTRL_CLEAR  = 5; // clear count pulse

  // status fields
  localparam int STAT_RUN  = 0;
  localparam int STAT_DIR  = 1;
  localparam int STAT_WRAP = 2;

  // event bits: 0 tick, 1 wrap
  localparam int EVT_TICK = 0;
  localparam int EVT_WRAP = 1;
  localparam int EVT_N    = 2;

  localparam logic MODE_QUAD = 1'b0; // default
  localparam logic MODE_STEP = 1'b1;

  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage : etc_pkg

//--- hw/etc_decoder.sv
// tick decoder: synchronises encoder inputs and emits up/down ticks
// assumes inputs are already sampled on CLK; mode is quasi-static
`timescale 1ns/1ps
`default_nettype none
module etc_decoder (
  input  wire logic clk,      // system clock
  input  wire logic rst_n,    // synchronous active-low reset
  input  wire logic mode,     // 0 quadrature, 1 step/direction
  input  wire logic in_a,     // phase a or step
  input  wire logic in_b,     // phase b or direction
  output logic      tick,     // one-cycle count event
  output logic      down      // direction of that event
);
  // ****************************************************************
  // two-flop synchronisers plus one history stage
  // ****************************************************************
  logic [1:0] s1_r;   // first stage, read only by s2_r
  logic [1:0] s2_r;   // synchronised
  logic [1:0] prev_r; // previous synchronised value

  // sync chain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r   <= 2'h0;
      s2_r   <= 2'h0;
      prev_r <= 2'h0;
    end else begin
      s1_r   <= {in_b, in_a};
      s2_r   <= s1_r;
      prev_r <= s2_r;
    end
  end

  // ****************************************************************
  // edge decode
  // ****************************************************************
  always_comb begin
    tick = 1'b0;
    down = 1'b0;
    if (mode == etc_pkg::MODE_STEP) begin
      // rising step edge, direction level picks sign
      tick = s2_r[0] & ~prev_r[0];
      down = s2_r[1];
    end else begin
      // any edge on a or b counts
      tick = (s2_r[0] ^ prev_r[0]) | (s2_r[1] ^ prev_r[1]);
      // a leading b counts up: new a differs from old b when a moved
      if (s2_r[0] ^ prev_r[0])
        down = s2_r[0] == prev_r[1];
      else
        down = s2_r[1] != prev_r[0];
    end
  end
endmodule : etc_decoder
`default_nettype wire

//--- tb/etc_enc_model.sv
// encoder model: drives quadrature phases or step/direction pins
// assumes the bench calls its tasks from one process, just after CLK edges
`timescale 1ns/1ps
`default_nettype none
module etc_enc_model (
  input  wire logic CLK,   // system clock
  output logic      ENC_A, // phase a or step
  output logic      ENC_B  // phase b or direction
);
  int pos = 0; // place in the four-state gray cycle

  initial begin
    ENC_A = 1'h0;
    ENC_B = 1'h0;
  end

  // one gray step per 4 clocks, phases a quarter apart, a leads b going up
  task automatic quad(input int n, input logic dn);
    for (int i = 0; i < n; i++) begin
      pos = dn ? pos + 3 : pos + 1;
      @(posedge CLK);
      ENC_A <= (pos % 4 == 1) || (pos % 4 == 2);
      ENC_B <= (pos % 4 >= 2);
      repeat (3) @(posedge CLK);
    end
  endtask : quad

  // direction settles before the first step edge, each level 4 clocks
  task automatic step(input int n, input logic dn);
    @(posedge CLK);
    ENC_B <= dn;
    repeat (3) @(posedge CLK);
    for (int i = 0; i < n; i++) begin
      ENC_A <= 1'h1;
      repeat (4) @(posedge CLK);
      ENC_A <= 1'h0;
      repeat (4) @(posedge CLK);
    end
  endtask : step
endmodule : etc_enc_model
`default_nettype wire

//--- tb/tb_top.sv
// bench for the encoder tick counter: apb master tasks and scenarios
// assumes etc_top and etc_pkg compiled first, model in etc_enc_model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  logic        clk = 1'h0; // 25 MHz clock
  logic        rst_n;      // active-low reset
  logic        psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;      // byte address
  logic [31:0] pwdata, prdata, rdat;
  logic        enc_a, enc_b;
  logic        rerr;       // error flag taken with the read data
  int          bad_count = 0;
  int          checks = 0;

  always #20 clk = ~clk;

  etc_top etc_top_inst (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .ENC_A(enc_a), .ENC_B(enc_b), .IRQ(irq));
  etc_enc_model etc_enc_model_inst (.CLK(clk), .ENC_A(enc_a), .ENC_B(enc_b));

  // ****************************************************************
  // bus tasks
  // ****************************************************************
  task automatic conclude;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  // one apb transfer, held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin @(posedge clk); n++; end while (pready !== 1'h1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin bad_count++; conclude(); end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'h1, a, d); endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e); apb(1'h0, a, 32'h0); `CHK(rdat, e) endtask : rc

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_quad; // open with defaults, count up then down
    wr(etc_pkg::ADDR_CTRL, 32'h1 << etc_pkg::CTRL_OPEN);
    rc(etc_pkg::ADDR_CTRL, 32'h0);
    rc(etc_pkg::ADDR_STATUS, 32'h1);
    etc_enc_model_inst.quad(8, 1'h0);
    rc(etc_pkg::ADDR_COUNT, 32'h8);
    rc(etc_pkg::ADDR_STATUS, 32'h1);
    etc_enc_model_inst.quad(3, 1'h1);
    rc(etc_pkg::ADDR_COUNT, 32'h5);
    rc(etc_pkg::ADDR_STATUS, 32'h3);
  endtask : t_quad

  task automatic t_stop; // frozen while stopped, resumes on start
    wr(etc_pkg::ADDR_CTRL, 32'h1 << etc_pkg::CTRL_STOP);
    etc_enc_model_inst.quad(4, 1'h0);
    rc(etc_pkg::ADDR_COUNT, 32'h5);
    wr(etc_pkg::ADDR_CTRL, 32'h1 << etc_pkg::CTRL_START);
    etc_enc_model_inst.quad(4, 1'h0);
    rc(etc_pkg::ADDR_COUNT, 32'h9);
  endtask : t_stop

  task automatic t_wrap; // clear, wrap below zero, interrupt mask and w1c
    wr(etc_pkg::ADDR_CTRL, 32'h1 << etc_pkg::CTRL_CLEAR);
    rc(etc_pkg::ADDR_COUNT, 32'h0);
    wr(etc_pkg::ADDR_IRQ_ST, 32'h3);
    wr(etc_pkg::ADDR_IRQ_MK, 32'h1 << etc_pkg::EVT_WRAP);
    etc_enc_model_inst.quad(1, 1'h1);
    rc(etc_pkg::ADDR_COUNT, 32'hffff_ffff);
    rc(etc_pkg::ADDR_STATUS, 32'h7);
    `CHK(irq, 1'h1)
    rc(etc_pkg::ADDR_IRQ_ST, 32'h3);
    wr(etc_pkg::ADDR_IRQ_MK, 32'h0);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'h0)
    wr(etc_pkg::ADDR_IRQ_MK, 32'h2);
    wr(etc_pkg::ADDR_IRQ_ST, 32'h2);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'h0)
    rc(etc_pkg::ADDR_IRQ_ST, 32'h1);
    apb(1'h0, 8'h20, 32'h0);
    `CHK({rerr, rdat}, 33'h1_0000_0000)
  endtask : t_wrap

  task automatic t_step; // reopen in step mode without starting
    wr(etc_pkg::ADDR_CTRL, 32'h7);
    rc(etc_pkg::ADDR_CTRL, 32'h1);
    etc_enc_model_inst.step(2, 1'h0);
    rc(etc_pkg::ADDR_COUNT, 32'h0);
    wr(etc_pkg::ADDR_CTRL, 32'h1 << etc_pkg::CTRL_START);
    etc_enc_model_inst.step(3, 1'h0);
    etc_enc_model_inst.step(2, 1'h1);
    rc(etc_pkg::ADDR_COUNT, 32'h1);
    rc(etc_pkg::ADDR_STATUS, 32'h3);
  endtask : t_step

  // reset for 5 cycles, then run every scenario
  initial begin
    rst_n = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 8'h0; pwdata = 32'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    rc(etc_pkg::ADDR_STATUS, 32'h0);
    t_quad();
    t_stop();
    t_wrap();
    t_step();
    conclude();
  end
endmodule : tb_top
`default_nettype wire
